//--- rtl/pirqe_pkg.sv
package pirqe_pkg;
  // register offsets on the plain register port
  localparam logic [7:0] PIRQE_OFS_ENABLE   = 8'h8c;
  localparam logic [7:0] PIRQE_OFS_CONTROL  = 8'h8b;
  localparam logic [7:0] PIRQE_OFS_STATUS   = 8'h90;
  localparam logic [7:0] PIRQE_OFS_MASK     = 8'h91;
  localparam logic [7:0] PIRQE_OFS_RAW      = 8'h92;
  // enable register field positions
  localparam int PIRQE_BIT_PAR_PORT   = 7;
  localparam int PIRQE_BIT_CONV_DONE  = 6;
  localparam int PIRQE_BIT_RX         = 5;
  localparam int PIRQE_BIT_TX         = 4;
  localparam int PIRQE_BIT_SYNC_SER   = 3;
  localparam int PIRQE_BIT_CAP_CMP    = 2;
  localparam int PIRQE_BIT_PERIOD     = 1;
  localparam int PIRQE_BIT_CNT_OVF    = 0;
  // control register: global peripheral enable position
  localparam int PIRQE_BIT_GLOBAL_EN  = 6;
  // reset values
  localparam logic [7:0] PIRQE_RST_ENABLE  = 8'h00;
  localparam logic [7:0] PIRQE_RST_CONTROL = 8'h00;
  localparam logic [7:0] PIRQE_RST_MASK    = 8'h00;
  localparam logic [7:0] PIRQE_RST_STATUS  = 8'h00;
endpackage

//--- rtl/pirqe_gate.sv
`timescale 1ns/1ps
module pirqe_gate
  import pirqe_pkg::*;
#(
  parameter int N = 8
) (
  input  wire logic [N-1:0] req,
  input  wire logic [N-1:0] en,
  input  wire logic         global_en,
  output logic      [N-1:0] gated
);
  initial begin
    if (N < 1) $error("pirqe_gate: N must be at least 1");
  end

  // one gate per source, all behind the global enable
  genvar i;
  generate
    for (i = 0; i < N; i++) begin : g_src
      assign gated[i] = req[i] & en[i] & global_en; // [RULE1] [RULE2]
    end
  endgenerate
endmodule

//--- rtl/pirqe_top.sv
// What this block does
// [RULE1] every peripheral request blocked unless global enable, control bit 6, is set
// [RULE2] one enable bit per source; set passes, clear blocks that request
// [RULE3] enable bit 7 gates the parallel port read/write request
// [RULE4] software keeps bit 7 clear on the small package without parallel port
// [RULE5] enable bit 6 gates the converter completion request
//
// Design decision made here: the strobed register port.
`timescale 1ns/1ps
module pirqe_top
  import pirqe_pkg::*;
#(
  parameter int N_SRC = 8
) (
  input  wire logic             mclk,
  input  wire logic             rst,
  input  wire logic [7:0]       addr,
  input  wire logic [7:0]       wdata,
  input  wire logic             wr,
  input  wire logic             rd,
  output logic      [7:0]       rdata,
  input  wire logic [N_SRC-1:0] src_req,
  output logic      [N_SRC-1:0] irq_req,
  output logic                  periph_irq,
  output logic                  irq
);
  initial begin
    if (N_SRC != 8) $error("pirqe_top: N_SRC must be 8");
  end

  logic [7:0] periph_irq_enable_reg;
  logic [7:0] irq_control_reg;
  logic [7:0] status_r;
  logic [7:0] mask_r;
  logic [7:0] rdata_nxt;
  logic [7:0] gated;
  logic [7:0] gated_d_r;
  logic [7:0] rise;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    return a == ofs;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // registers
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      periph_irq_enable_reg <= PIRQE_RST_ENABLE;
    end else if (wr && hit(addr, PIRQE_OFS_ENABLE)) begin
      // bit 7 stays writable; keeping it clear without the port is software's job
      periph_irq_enable_reg <= wdata; // [RULE2] [RULE3] [RULE5]
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      irq_control_reg <= PIRQE_RST_CONTROL;
    end else if (wr && hit(addr, PIRQE_OFS_CONTROL)) begin
      irq_control_reg <= wdata;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      mask_r <= PIRQE_RST_MASK;
    end else if (wr && hit(addr, PIRQE_OFS_MASK)) begin
      mask_r <= wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // gating
  pirqe_gate #(
    .N (8)
  ) u_gate (
    .req       (src_req),
    .en        (periph_irq_enable_reg),
    .global_en (irq_control_reg[PIRQE_BIT_GLOBAL_EN]), // [RULE1]
    .gated     (gated)
  );

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      irq_req    <= 8'h00;
      periph_irq <= 1'b0;
      gated_d_r  <= 8'h00;
    end else begin
      irq_req    <= gated; // [RULE3] [RULE5]
      periph_irq <= |gated; // [RULE1]
      gated_d_r  <= gated;
    end
  end

  // a rising gated request is the event; level alone would re-set after clear
  assign rise = gated & ~gated_d_r;

  ////////////////////////////////////////////////////////////////////////////
  // sticky status, cleared by reading it; a new event in that cycle wins
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      status_r <= PIRQE_RST_STATUS;
    end else if (rd && hit(addr, PIRQE_OFS_STATUS)) begin
      status_r <= rise;
    end else begin
      status_r <= status_r | rise;
    end
  end

  assign irq = |(status_r & mask_r);

  ////////////////////////////////////////////////////////////////////////////
  // read port
  always_comb begin
    rdata_nxt = 8'h00;
    if (hit(addr, PIRQE_OFS_ENABLE)) rdata_nxt = periph_irq_enable_reg;
    if (hit(addr, PIRQE_OFS_CONTROL)) rdata_nxt = irq_control_reg;
    if (hit(addr, PIRQE_OFS_STATUS)) rdata_nxt = status_r;
    if (hit(addr, PIRQE_OFS_MASK)) rdata_nxt = mask_r;
    if (hit(addr, PIRQE_OFS_RAW)) rdata_nxt = src_req;
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rdata <= 8'h00;
    end else if (rd) begin
      rdata <= rdata_nxt;
    end else begin
      rdata <= 8'h00;
    end
  end
endmodule

//--- bench/pirqe_chk.sv
`timescale 1ns/1ps
module pirqe_chk
  import pirqe_pkg::*;
#(parameter int N_SRC = 8) (
  input wire logic             mclk,
  input wire logic             rst,
  input wire logic [7:0]       addr,
  input wire logic [7:0]       wdata,
  input wire logic             wr,
  input wire logic [N_SRC-1:0] src_req,
  input wire logic [N_SRC-1:0] irq_req,
  input wire logic             periph_irq
);
  // shadow of the two gating registers, built from bus writes
  logic [N_SRC-1:0] en_r;
  logic             gl_r;
  always_ff @(posedge mclk or posedge rst)
    if (rst) {en_r, gl_r} <= '0;
    else if (wr && addr == PIRQE_OFS_ENABLE) en_r <= wdata[N_SRC-1:0];
    else if (wr && addr == PIRQE_OFS_CONTROL) gl_r <= wdata[PIRQE_BIT_GLOBAL_EN];
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  sequence s_off; !gl_r; endsequence
  property p_global; s_off |=> irq_req == '0 && !periph_irq; endproperty
  a_global: assert property (p_global) else $error("request passed while off");
  property p_each;
    1 |=> irq_req == $past(src_req & en_r & {N_SRC{gl_r}}) && periph_irq == |irq_req;
  endproperty
  a_each: assert property (p_each) else $error("gated request wrong");
  property p_par; src_req[7] && en_r[7] && gl_r |=> irq_req[7]; endproperty
  a_par: assert property (p_par) else $error("parallel port request lost");
  property p_conv; !en_r[6] |=> !irq_req[6]; endproperty
  a_conv: assert property (p_conv) else $error("converter request not blocked");
endmodule
bind pirqe_top pirqe_chk #(.N_SRC(N_SRC)) u_chk (.mclk(mclk), .rst(rst), .addr(addr),
  .wdata(wdata), .wr(wr), .src_req(src_req), .irq_req(irq_req), .periph_irq(periph_irq));

//--- bench/pirqe_src.sv
`timescale 1ns/1ps
module pirqe_src (
  input wire logic       mclk,
  input wire logic       rst,
  input wire logic [7:0] pat,
  output logic     [7:0] src_req
);
  // level requests, held until the source drops them
  always_ff @(posedge mclk or posedge rst)
    if (rst) src_req <= '0;
    else src_req <= pat;
endmodule

//--- bench/peripheral_irq_enable_test.sv
`timescale 1ns/1ps
module peripheral_irq_enable_test;
  import pirqe_pkg::*;
  logic mclk, rst, wr, rd, rd_d, look, irq, periph_irq;
  logic [7:0] addr, wdata, rdata, pat, src_req, irq_req, e, c, p;
  logic [9:0] q[$];
  int miscompares = 0, checks = 0, i;
  int unsigned s = 48;
  pirqe_src u_pirqe_src (.mclk(mclk), .rst(rst), .pat(pat), .src_req(src_req));
  pirqe_top u_pirqe_top (.mclk(mclk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .src_req(src_req), .irq_req(irq_req),
    .periph_irq(periph_irq), .irq(irq));
  function automatic logic [7:0] rnd();
    s ^= s << 13; s ^= s >> 17; s ^= s << 5;
    return s[7:0];
  endfunction
  task automatic wr8(input logic [7:0] a, d);
    @(posedge mclk); addr <= a; wdata <= d; wr <= 1;
    @(posedge mclk); wr <= 0;
  endtask
  task automatic rd8(input logic [7:0] a, d);
    q.push_back({2'b00, d});
    @(posedge mclk); addr <= a; rd <= 1;
    @(posedge mclk); rd <= 0;
  endtask
  // requests need three edges: source register, gate register, settle
  task automatic chk(input logic [7:0] v, input logic [9:0] x);
    q.push_back(x);
    @(posedge mclk); pat <= v;
    repeat (3) @(posedge mclk);
    look <= 1;
    @(posedge mclk); look <= 0;
  endtask
  task automatic summarize();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  always @(posedge mclk) rd_d <= rd;
  always @(negedge mclk) if (rd_d || look) begin
    logic [9:0] g, x;
    g = rd_d ? {2'b00, rdata} : {irq, periph_irq, irq_req};
    x = q.size() ? q.pop_front() : 10'h3ff;
    checks++;
    if (g !== x) begin
      miscompares++;
      $display("MISMATCH t=%0t got %h exp %h", $time, g, x);
    end
  end
  initial begin
    mclk = 0;
    forever #10 mclk = ~mclk;
  end
  initial begin
    {addr, wdata, wr, rd, rd_d, look, pat} = '0; rst = 1;
    repeat (6) @(posedge mclk); rst <= 0;
    rd8(PIRQE_OFS_ENABLE, 8'h00); rd8(PIRQE_OFS_CONTROL, 8'h00); rd8(8'h55, 8'h00);
    wr8(PIRQE_OFS_ENABLE, 8'hff); rd8(PIRQE_OFS_ENABLE, 8'hff);
    chk(8'hff, 10'h000);
    wr8(PIRQE_OFS_CONTROL, 8'h40); chk(8'hff, 10'h1ff);
    wr8(PIRQE_OFS_MASK, 8'h20); chk(8'hff, 10'h3ff);
    rd8(PIRQE_OFS_STATUS, 8'hff); chk(8'hff, 10'h1ff);
    rd8(PIRQE_OFS_RAW, 8'hff);
    rd8(PIRQE_OFS_MASK, 8'h20);
    rd8(PIRQE_OFS_CONTROL, 8'h40);
    $display("end of reset, global and interrupt tests");
    for (i = 0; i < 8; i++) begin
      wr8(PIRQE_OFS_ENABLE, 8'h01 << i);
      chk(8'hff, {i >= 5, 1'b1, 8'h01 << i});
    end
    wr8(PIRQE_OFS_MASK, 8'h00);
    $display("end of per source test");
    // mid-run reset must bring enable, control and mask back to their reset values
    rst <= 1;
    @(posedge mclk);
    rst <= 0;
    rd8(PIRQE_OFS_ENABLE, 8'h00);
    rd8(PIRQE_OFS_CONTROL, 8'h00);
    rd8(PIRQE_OFS_MASK, 8'h00);
    $display("end of mid-run reset test");
    for (i = 0; i < 20; i++) begin
      e = rnd(); c = rnd(); p = rnd();
      wr8(PIRQE_OFS_ENABLE, {1'b0, e[6:0]});
      wr8(PIRQE_OFS_CONTROL, c);
      e[7] = 0; e = e & p & {8{c[6]}};
      chk(p, {1'b0, |e, e});
    end
    $display("end of random test");
    summarize();
  end
endmodule
